// File: hw/sadc_ctrl.sv
// Purpose: Sample/convert sequencing, result buffering and event flags
// Assumes: Analog core converts on conv_start_o and pulses core_done_i
// Notes: Configuration is plain ports; software strobes are one-cycle pulses
// Function
// - Ten-bit mode by default with one, two or four holds set by sh_count; twelve-bit single-hold when selected.
// - Ten-bit samples up to four inputs together; twelve-bit samples one.
// - Up to nine analog inputs plus two shareable reference inputs.
// - Each event flag set issues one DMA request.
// - Samples-per-event count sets DMA pointer increment spacing.
// - Build order gives buffer pointer as address, sequential without DMA, held at zero with DMA; otherwise input-indexed scatter/gather address.
// - Samples-per-event count decides when the event flag sets.
// - Scan list restarts from first selected input at each event.
// - Without DMA, sixteen sequential buffers, pointer reset at each event.
// - With DMA, one buffer overwritten by each conversion; reader must keep up.
// - Done flag clears at conversion start, sets at completion, holds meanwhile.
// - Pin reads digital only when both converters' configuration bits are one.
// - Result format selects integer, signed, fractional or signed fractional layouts.
// - Trigger source selects what ends sampling; code six is reserved.
// - Auto sample restarts sampling after conversion; else software sets sample.
// - Software may clear done but not set it; no effect on conversion.
module sadc_ctrl (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire sadc_pkg::sadc_cfg_s cfg_i,
	input wire logic sample_set_i,
	input wire logic sample_clr_i,
	input wire logic done_clr_i,
	input wire logic event_clr_i,
	input wire logic ext_trig_pin_i,
	input wire logic tmr_a_i,
	input wire logic tmr_b_i,
	input wire logic pwm_a_i,
	input wire logic pwm_b_i,
	input wire logic core_done_i,
	input wire logic [11:0] core_raw_i,
	input wire logic [3:0] buf_rd_idx_i,
	input wire logic [8:0] pin_cfg_self_i,
	input wire logic [8:0] pin_cfg_other_i,
	output logic [8:0] digital_en_o,
	output logic conv_start_o,
	output logic [3:0] sh_enable_o,
	output logic [3:0] input_sel_o,
	output logic sample_control_o,
	output logic done_o,
	output logic conversion_event_flag_o,
	output logic dma_req_o,
	output sadc_pkg::sadc_result_s result_o,
	output logic [sadc_pkg::SADC_DATA_W-1:0] buf_rd_data_o
);
	import sadc_pkg::*;

	// ==========================================
	// Scan helpers
	// ==========================================
	function automatic logic [3:0] next_sel(input logic [15:0] mask, input logic [3:0] from,
		input logic first);
		logic [3:0] r;
		logic hit;
		r = 4'h0;
		hit = 1'b0;
		for (int k = 0; k < SADC_NUM_INPUTS; k++) begin
			if (!hit && mask[k] && (first || k > int'(from))) begin
				r = 4'(k);
				hit = 1'b1;
			end
		end
		if (!hit) begin
			for (int k = SADC_NUM_INPUTS - 1; k >= 0; k--) begin
				if (mask[k]) begin
					r = 4'(k);
				end
			end
		end
		return r;
	endfunction

	// ==========================================
	// Pin digital enable
	// ==========================================
	assign digital_en_o = pin_cfg_self_i & pin_cfg_other_i;

	// ==========================================
	// Trigger pins synchronised
	// ==========================================
	logic [4:0] trg_meta_reg, trg_sync_reg, trg_last_reg;
	logic [4:0] trg_rise;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trg_meta_reg <= 5'h00;
			trg_sync_reg <= 5'h00;
			trg_last_reg <= 5'h00;
		end else begin
			trg_meta_reg <= {pwm_b_i, pwm_a_i, tmr_b_i, tmr_a_i, ext_trig_pin_i};
			trg_sync_reg <= trg_meta_reg;
			trg_last_reg <= trg_sync_reg;
		end
	end
	assign trg_rise = trg_sync_reg & ~trg_last_reg;

	// ==========================================
	// Sequencer
	// ==========================================
	sadc_state_e state_reg, state_next;
	logic done_reg, done_next;
	logic sample_control_reg, sample_control_next;
	logic evt_reg, evt_next;
	logic dma_req_reg, dma_req_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [3:0] ptr_reg, ptr_next;
	logic [3:0] sel_reg, sel_next;
	logic [4:0] auto_reg, auto_next;
	logic [10:0] dma_ptr_reg, dma_ptr_next;
	sadc_result_s res_reg, res_next;
	logic [SADC_DATA_W-1:0] bufs_reg [SADC_NUM_BUFS];
	logic [SADC_DATA_W-1:0] fmt_data;
	logic end_sample;
	logic event_hit;

	sadc_format u_format (
		.raw_i(core_raw_i),
		.wide_i(cfg_i.resolution_select),
		.format_i(cfg_i.result_format),
		.data_o(fmt_data)
	);

	always_comb begin
		end_sample = 1'b0;
		case (cfg_i.trigger_source)
			SADC_TRIG_SW: end_sample = sample_clr_i;
			SADC_TRIG_EXT: end_sample = trg_rise[0];
			SADC_TRIG_TMR_A: end_sample = trg_rise[1];
			SADC_TRIG_TMR_B: end_sample = trg_rise[2];
			SADC_TRIG_PWM_A: end_sample = trg_rise[3];
			SADC_TRIG_PWM_B: end_sample = trg_rise[4];
			SADC_TRIG_AUTO: end_sample = (auto_reg == SADC_AUTO_SAMPLE_CYC);
			default: end_sample = 1'b0;
		endcase
	end

	assign event_hit = core_done_i && (cnt_reg == cfg_i.samples_per_event);

	always_comb begin
		state_next = state_reg;
		done_next = done_reg;
		sample_control_next = sample_control_reg;
		evt_next = evt_reg;
		dma_req_next = 1'b0;
		cnt_next = cnt_reg;
		ptr_next = ptr_reg;
		sel_next = sel_reg;
		auto_next = auto_reg;
		dma_ptr_next = dma_ptr_reg;
		res_next = res_reg;
		if (done_clr_i) begin
			done_next = 1'b0;
		end
		if (event_clr_i) begin
			evt_next = 1'b0;
		end
		if (!cfg_i.module_on) begin
			state_next = SADC_IDLE;
			sample_control_next = 1'b0;
			cnt_next = 4'h0;
			ptr_next = 4'h0;
			auto_next = 5'h00;
			sel_next = next_sel(cfg_i.scan_select, 4'h0, 1'b1);
		end else begin
			case (state_reg)
				SADC_IDLE: begin
					if (sample_set_i || cfg_i.auto_sample) begin
						state_next = SADC_SAMPLE;
						sample_control_next = 1'b1;
						auto_next = 5'h00;
					end
				end
				SADC_SAMPLE: begin
					auto_next = auto_reg + 5'h01;
					if (end_sample) begin
						state_next = SADC_CONVERT;
						sample_control_next = 1'b0;
						done_next = 1'b0;
					end
				end
				default: begin
					if (core_done_i) begin
						done_next = 1'b1;
						res_next.data = fmt_data;
						res_next.index = cfg_i.scan_enable ? sel_reg : cfg_i.fixed_input;
						if (cfg_i.dma_build_order) begin
							res_next.dma_addr = {7'h00, ptr_reg};
						end else begin
							res_next.dma_addr = 11'(({7'h00, res_next.index} << cfg_i.dma_buf_log2)
								+ dma_ptr_reg);
						end
						if (!cfg_i.dma_present) begin
							ptr_next = event_hit ? 4'h0 : ptr_reg + 4'h1;
						end
						sel_next = next_sel(cfg_i.scan_select, sel_reg, event_hit);
						if (event_hit) begin
							cnt_next = 4'h0;
							evt_next = 1'b1;
							dma_req_next = cfg_i.dma_present;
							dma_ptr_next = dma_ptr_reg + 11'h001;
						end else begin
							cnt_next = cnt_reg + 4'h1;
						end
						state_next = cfg_i.auto_sample ? SADC_SAMPLE : SADC_IDLE;
						sample_control_next = cfg_i.auto_sample;
						auto_next = 5'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= SADC_IDLE;
			done_reg <= 1'b0;
			sample_control_reg <= 1'b0;
			evt_reg <= 1'b0;
			dma_req_reg <= 1'b0;
			cnt_reg <= 4'h0;
			ptr_reg <= 4'h0;
			sel_reg <= 4'h0;
			auto_reg <= 5'h00;
			dma_ptr_reg <= 11'h000;
			res_reg <= '0;
		end else begin
			state_reg <= state_next;
			done_reg <= done_next;
			sample_control_reg <= sample_control_next;
			evt_reg <= evt_next;
			dma_req_reg <= dma_req_next;
			cnt_reg <= cnt_next;
			ptr_reg <= ptr_next;
			sel_reg <= sel_next;
			auto_reg <= auto_next;
			dma_ptr_reg <= dma_ptr_next;
			res_reg <= res_next;
		end
	end

	// Sixteen-entry store only used without DMA; with DMA entry 0 is overwritten
	always_ff @(posedge sys_clk_i) begin
		if (state_reg == SADC_CONVERT && core_done_i && cfg_i.module_on) begin
			bufs_reg[cfg_i.dma_present ? 4'h0 : ptr_reg] <= fmt_data;
		end
	end

	// ==========================================
	// Outputs
	// ==========================================
	assign conv_start_o = (state_reg == SADC_SAMPLE) && end_sample && cfg_i.module_on;
	// Twelve-bit mode forces a single hold amplifier
	assign sh_enable_o = cfg_i.resolution_select ? 4'h1 :
		(cfg_i.sh_count == 2'h0 ? 4'h1 : (cfg_i.sh_count == 2'h1 ? 4'h3 : 4'hf));
	assign input_sel_o = cfg_i.scan_enable ? sel_reg : cfg_i.fixed_input;
	assign sample_control_o = sample_control_reg;
	assign done_o = done_reg;
	assign conversion_event_flag_o = evt_reg;
	assign dma_req_o = dma_req_reg;
	assign result_o = res_reg;
	assign buf_rd_data_o = bufs_reg[cfg_i.dma_present ? 4'h0 : buf_rd_idx_i];
endmodule // sadc_ctrl

// File: hw/sadc_format.sv
// Purpose: Encodes a raw conversion into the selected output layout
// Assumes: Raw data right aligned
// Notes: Purely combinational
module sadc_format (
	input wire logic [11:0] raw_i,
	input wire logic wide_i,
	input wire logic [1:0] format_i,
	output logic [sadc_pkg::SADC_DATA_W-1:0] data_o
);
	import sadc_pkg::*;
	logic [11:0] v;
	logic s;
	always_comb begin
		v = wide_i ? raw_i : {2'h0, raw_i[9:0]};
		s = wide_i ? ~raw_i[11] : ~raw_i[9];
		data_o = 16'h0000;
		case (format_i)
			SADC_FMT_SFRAC: data_o = wide_i ? {s, raw_i[10:0], 4'h0} : {s, raw_i[8:0], 6'h00};
			SADC_FMT_FRAC: data_o = wide_i ? {raw_i, 4'h0} : {raw_i[9:0], 6'h00};
			SADC_FMT_SINT: data_o = wide_i ? {{5{s}}, raw_i[10:0]} : {{7{s}}, raw_i[8:0]};
			default: data_o = {4'h0, v};
		endcase
	end
endmodule // sadc_format

// File: hw/sadc_pkg.sv
// Purpose: Shared constants and types for the converter sequencer control
// Assumes: 50 MHz system clock, one domain
// Notes: Analog core outside; it reports raw results with a done pulse
package sadc_pkg;
	localparam int SADC_NUM_INPUTS = 9;
	localparam int SADC_NUM_SH = 4;
	localparam int SADC_NUM_BUFS = 16;
	localparam int SADC_RES10 = 10;
	localparam int SADC_RES12 = 12;
	localparam int SADC_DATA_W = 16;
	localparam logic [1:0] SADC_FMT_INT = 2'h0;
	localparam logic [1:0] SADC_FMT_SINT = 2'h1;
	localparam logic [1:0] SADC_FMT_FRAC = 2'h2;
	localparam logic [1:0] SADC_FMT_SFRAC = 2'h3;
	localparam logic [2:0] SADC_TRIG_SW = 3'h0;
	localparam logic [2:0] SADC_TRIG_EXT = 3'h1;
	localparam logic [2:0] SADC_TRIG_TMR_A = 3'h2;
	localparam logic [2:0] SADC_TRIG_PWM_A = 3'h3;
	localparam logic [2:0] SADC_TRIG_TMR_B = 3'h4;
	localparam logic [2:0] SADC_TRIG_PWM_B = 3'h5;
	localparam logic [2:0] SADC_TRIG_RSVD = 3'h6;
	localparam logic [2:0] SADC_TRIG_AUTO = 3'h7;
	localparam logic [4:0] SADC_AUTO_SAMPLE_CYC = 5'h1f;

	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_SAMPLE,
		SADC_CONVERT
	} sadc_state_e;

	typedef struct packed {
		logic module_on;
		logic resolution_select;
		logic dma_present;
		logic dma_build_order;
		logic scan_enable;
		logic auto_sample;
		logic [1:0] result_format;
		logic [2:0] trigger_source;
		logic [3:0] samples_per_event;
		logic [1:0] sh_count;
		logic [3:0] fixed_input;
		logic [15:0] scan_select;
		logic [3:0] dma_buf_log2;
	} sadc_cfg_s;

	typedef struct packed {
		logic [SADC_DATA_W-1:0] data;
		logic [3:0] index;
		logic [10:0] dma_addr;
	} sadc_result_s;
endpackage

// File: tb/sadc_core_model.sv
// Purpose: Analog core stand-in answering conversion starts
// Assumes: Start is a one-cycle pulse
// Notes: Latency is a port so one run covers prompt and slow
module sadc_core_model (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic start_i,
	input wire logic [7:0] lat_i,
	input wire logic [11:0] val_i,
	output logic done_o,
	output logic [11:0] raw_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	logic busy;
	// Raw bus is garbage outside the done pulse
	assign raw_o = done_o ? val_i : ~val_i;
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy <= 1'b0;
			cnt <= 8'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= busy && cnt == 8'h0;
			if (start_i) begin
				busy <= 1'b1;
				cnt <= lat_i;
			end else if (busy) begin
				busy <= cnt != 8'h0;
				cnt <= cnt - 8'h1;
			end
		end
	end
endmodule // sadc_core_model

// File: tb/sadc_ctrl_props.sv
// Purpose: Port checks for the sequencer control
// Assumes: One clock, async active-low reset
// Notes: Bound to every sadc_ctrl instance
module sadc_ctrl_props (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire sadc_pkg::sadc_cfg_s cfg_i,
	input wire logic done_clr_i,
	input wire logic event_clr_i,
	input wire logic core_done_i,
	input wire logic [8:0] pin_cfg_self_i,
	input wire logic [8:0] pin_cfg_other_i,
	input wire logic [8:0] digital_en_o,
	input wire logic conv_start_o,
	input wire logic sample_control_o,
	input wire logic done_o,
	input wire logic conversion_event_flag_o,
	input wire logic dma_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ========
	// Assertions
	AST_DIG_EN: assert property (digital_en_o == (pin_cfg_self_i & pin_cfg_other_i))
		else $error("digital enable wrong");
	AST_DONE_SET: assert property ($rose(done_o) |-> $past(core_done_i))
		else $error("done rose without completion");
	AST_DONE_START: assert property (conv_start_o |=> !done_o)
		else $error("done kept at start");
	AST_DONE_HOLD: assert property ($fell(done_o) |-> $past(conv_start_o || done_clr_i))
		else $error("done fell by itself");
	AST_DMA_EVT: assert property (dma_req_o |-> conversion_event_flag_o && done_o)
		else $error("dma request without event");
	AST_EVT_HOLD: assert property ($fell(conversion_event_flag_o) |-> $past(event_clr_i))
		else $error("event flag fell by itself");
	AST_SAMPLE_CONTROL_END: assert property (conv_start_o |=> !sample_control_o)
		else $error("sampling kept after start");
	AST_RSVD: assert property (cfg_i.trigger_source == SADC_TRIG_RSVD |-> !conv_start_o)
		else $error("reserved trigger started");
	C_EVT: cover property ($rose(conversion_event_flag_o));
	C_DMA: cover property (dma_req_o);
	C_CLR: cover property (done_o && done_clr_i);
endmodule // sadc_ctrl_props

bind sadc_ctrl sadc_ctrl_props i_sadc_ctrl_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
	.cfg_i(cfg_i), .done_clr_i(done_clr_i), .event_clr_i(event_clr_i), .core_done_i(core_done_i),
	.pin_cfg_self_i(pin_cfg_self_i), .pin_cfg_other_i(pin_cfg_other_i),
	.digital_en_o(digital_en_o), .conv_start_o(conv_start_o), .done_o(done_o),
	.sample_control_o(sample_control_o), .conversion_event_flag_o(conversion_event_flag_o),
	.dma_req_o(dma_req_o));

// File: tb/tb.sv
// Purpose: Self-checking bench for the sequencer control
// Assumes: 50 MHz clock, inputs driven 2 ns after rising edge
// Notes: Trigger pins come from one vector indexed by trigger code minus one
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	sadc_cfg_s cfg = '0;
	logic s_set = 1'b0, s_clr = 1'b0, d_clr = 1'b0, e_clr = 1'b0, c_done, c_start;
	logic sample_control, done, evt, dreq;
	logic [3:0] sh_en, in_sel;
	logic [4:0] trg = 5'h00;
	logic [11:0] c_raw, val = 12'h0;
	logic [3:0] rd_idx = 4'h0;
	logic [8:0] pc_self = 9'h0, pc_other = 9'h0, dig_en;
	logic [7:0] lat = 8'h2;
	logic [15:0] rd_data;
	sadc_result_s res;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	sadc_ctrl i_sadc_ctrl (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg),
		.sample_set_i(s_set), .sample_clr_i(s_clr), .done_clr_i(d_clr), .event_clr_i(e_clr),
		.ext_trig_pin_i(trg[0]), .tmr_a_i(trg[1]), .pwm_a_i(trg[2]), .tmr_b_i(trg[3]),
		.pwm_b_i(trg[4]),
		.core_done_i(c_done), .core_raw_i(c_raw), .buf_rd_idx_i(rd_idx),
		.pin_cfg_self_i(pc_self), .pin_cfg_other_i(pc_other), .digital_en_o(dig_en),
		.conv_start_o(c_start), .sh_enable_o(sh_en), .input_sel_o(in_sel),
		.sample_control_o(sample_control),
		.done_o(done), .conversion_event_flag_o(evt), .dma_req_o(dreq), .result_o(res),
		.buf_rd_data_o(rd_data));
	sadc_core_model i_sadc_core_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.start_i(c_start), .lat_i(lat), .val_i(val), .done_o(c_done), .raw_o(c_raw));
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// ========
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s: %h vs %h", $time, msg, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 90) begin
			step(1);
			n++;
		end
		chk(done, 1'b1, "done");
	endtask
	task automatic conv(input logic [11:0] v);
		val = v;
		pulse(d_clr);
		pulse(s_set);
		chk(sample_control, 1'b1, "sampling");
		pulse(s_clr);
		chk(done, 1'b0, "done at start");
		wait_done();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic logic [15:0] fmt(logic w, logic [1:0] f, logic [11:0] r);
		logic s;
		s = w ? ~r[11] : ~r[9];
		case ({w, f})
			3'h0: fmt = {6'h0, r[9:0]};
			3'h1: fmt = {{7{s}}, r[8:0]};
			3'h2: fmt = {r[9:0], 6'h0};
			3'h3: fmt = {s, r[8:0], 6'h0};
			3'h4: fmt = {4'h0, r};
			3'h5: fmt = {{5{s}}, r[10:0]};
			3'h6: fmt = {r, 4'h0};
			default: fmt = {s, r[10:0], 4'h0};
		endcase
	endfunction
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			$display("MISMATCH %0t timeout", $time);
			print_verdict();
		end
	end
	// ========
	// Tests
	initial begin
		step(8);
		arst_n_i = 1'b1;
		chk({done, evt, sample_control, dreq}, 4'h0, "reset");
		pc_self = 9'h1a5;
		pc_other = 9'h0ff;
		step(1);
		chk(dig_en, 9'h0a5, "digital enable");
		$display("test reset done");
		cfg.dma_present = 1'b1;
		cfg.sh_count = 2'h2;
		for (int i = 0; i < 8; i++) begin
			cfg.module_on = 1'b0;
			step(1);
			cfg.resolution_select = i[2];
			cfg.result_format = i[1:0];
			step(1);
			chk(sh_en, i[2] ? 4'h1 : 4'hf, "hold count");
			cfg.module_on = 1'b1;
			pulse(e_clr);
			conv(i[2] ? 12'h3a7 : 12'h2c5);
			chk(res.data, fmt(i[2], i[1:0], val), "format");
			chk(rd_data, fmt(i[2], i[1:0], val), "single buffer");
			chk({evt, dreq}, 2'h3, "event and dma");
		end
		$display("test formats done");
		cfg = '0;
		cfg.samples_per_event = 4'h3;
		cfg.dma_build_order = 1'b1;
		cfg.fixed_input = 4'h8;
		lat = 8'h0;
		step(1);
		cfg.module_on = 1'b1;
		pulse(e_clr);
		for (int i = 0; i < 5; i++) begin
			conv(12'h010 + i[11:0]);
			chk(evt, i == 3, "event count");
			chk(res.dma_addr, i[1:0], "ordered address");
			chk({res.index, in_sel}, 8'h88, "fixed input");
			if (i == 3) pulse(e_clr);
		end
		for (int i = 0; i < 4; i++) begin
			rd_idx = i[3:0];
			step(1);
			chk(rd_data, i == 0 ? 16'h0014 : 16'h0010 + i[15:0], "buffer");
		end
		$display("test buffers done");
		cfg.trigger_source = SADC_TRIG_RSVD;
		pulse(s_set);
		step(40);
		chk(sample_control, 1'b1, "reserved trigger");
		cfg.module_on = 1'b0;
		pulse(d_clr);
		chk(done, 1'b0, "done clear");
		cfg.auto_sample = 1'b1;
		cfg.trigger_source = SADC_TRIG_AUTO;
		lat = 8'h20;
		step(1);
		cfg.module_on = 1'b1;
		wait_done();
		step(2);
		chk(sample_control, 1'b1, "auto restart");
		cfg.module_on = 1'b0;
		$display("test triggers done");
		// Second reset also zeroes the event count behind the scatter address
		arst_n_i = 1'b0;
		step(2);
		arst_n_i = 1'b1;
		chk({done, evt, sample_control, dreq}, 4'h0, "second reset");
		cfg = '0;
		cfg.dma_present = 1'b1;
		cfg.scan_enable = 1'b1;
		cfg.scan_select = 16'h0052;
		cfg.samples_per_event = 4'h1;
		cfg.dma_buf_log2 = 4'h2;
		cfg.sh_count = 2'h1;
		lat = 8'h0;
		step(1);
		chk({sh_en, in_sel}, 8'h31, "scan setup");
		cfg.module_on = 1'b1;
		for (int i = 0; i < 4; i++) begin
			conv(12'h100 + i[11:0]);
			chk(res.index, i[0] ? 4'h4 : 4'h1, "scan index");
			chk(in_sel, i[0] ? 4'h1 : 4'h4, "scan next");
			chk(res.dma_addr, (i[0] ? 16'h0010 : 16'h0004) + 16'(i[1]), "scatter");
			chk({evt, dreq}, {i[0], i[0]}, "event every second");
			if (i[0]) pulse(e_clr);
		end
		$display("test scan done");
		for (int k = 1; k < 6; k++) begin
			cfg.trigger_source = k[2:0];
			pulse(d_clr);
			pulse(s_set);
			trg = ~(5'h01 << (k - 1));
			step(4);
			chk(sample_control, 1'b1, "other pin ignored");
			trg = 5'h1f;
			step(2);
			chk(sample_control, 1'b1, "pin synchronised");
			step(1);
			chk(sample_control, 1'b0, "pin ended sampling");
			wait_done();
			trg = 5'h00;
		end
		$display("test pins done");
		print_verdict();
	end
endmodule // tb
